// >>> inc/ftl_pkg.sv
// Package for the factory trim reset loader: register map, info-area
// locations, loader states and reset values.
// Assumes a 32-bit APB slave decode on the low twelve address bits.
package ftl_pkg;

   // -----------------------------------------------------------------
   // Register indices as printed; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [31:0] FTL_IDX_OSC_TRIM_FIRST = 32'h0FFFFF25;
   localparam logic [31:0] FTL_IDX_OSC_TRIM_SECOND = 32'hFFFFFF26;
   localparam logic [31:0] FTL_IDX_REFERENCE_TRIM = 32'hFFFFFF27;

   // Decoded address width and the index bits that are compared
   localparam int FTL_ADDR_W = 12;
   localparam int FTL_IDX_W = 10;

   // -----------------------------------------------------------------
   // Factory information area
   // -----------------------------------------------------------------
   localparam logic [7:0] FTL_INFO_OSC_FIRST = 8'h21;
   localparam logic [7:0] FTL_INFO_OSC_SECOND = 8'h22;
   localparam logic [7:0] FTL_INFO_REFERENCE = 8'h23;
   // Read-only window onto the info area: byte base, one word per byte
   localparam logic [11:0] FTL_INFO_WIN_BASE = 12'h400;
   localparam logic [1:0] FTL_INFO_WIN_SEL = 2'h1;

   // -----------------------------------------------------------------
   // Reset values and field layout
   // -----------------------------------------------------------------
   localparam logic [7:0] FTL_TRIM_RESET = 8'h00;
   localparam logic [31:0] FTL_RDATA_RESET = 32'h00000000;
   localparam int FTL_REF_ADJ_MSB = 4;
   localparam logic [7:0] FTL_REF_UNTRIMMED = 8'hF0;

   // -----------------------------------------------------------------
   // Loader and bus states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      FTL_ST_LOAD_OSC1 = 3'b000,
      FTL_ST_LOAD_OSC2 = 3'b001,
      FTL_ST_LOAD_REF = 3'b010,
      FTL_ST_RUN = 3'b011,
      FTL_ST_INFO_WAIT = 3'b100,
      FTL_ST_INFO_DONE = 3'b101
   } ftl_state_t;

endpackage : ftl_pkg

// >>> src/ftl_trim_loader.sv
// Factory trim reset loader: three eight-bit trim registers loaded from
// the factory information area after every reset, then open to software.
// Assumes an APB master on clock_in and an info-area read port on the
// same clock that answers a held request with a one-cycle acknowledge.
//
// Contract
// R1 - No write path into the information area
// R2 - Every reset reloads factory trim values
// R3 - Info-area reads return stored factory bytes
// R4 - Oscillator trims load from bytes 21h, 22h
// R5 - Reference trim loads from byte 23h
// R6 - Oscillator trims fully software read/write
// R7 - Software writes ones to reference bits 7:5
// R8 - Reference low five bits adjust; F0h untrimmed
// R9 - Hold software off until loading completes
// R10 - Trim registers drive the analogue blocks continuously
//
// Chosen here: the APB register port.
`timescale 1ns/100ps

module ftl_trim_loader
   import ftl_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [FTL_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Information area read port
   output logic info_req_out,
   output logic [7:0] info_addr_out,
   input wire logic info_ack_in,
   input wire logic [7:0] info_data_in,
   // Trim values to the analogue blocks
   output logic [7:0] osc_trim_first_out,
   output logic [7:0] osc_trim_second_out,
   output logic [7:0] reference_trim_out,
   output logic [FTL_REF_ADJ_MSB:0] reference_adjust_field_out,
   // Software execution released after loading
   output logic cpu_release_out
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   ftl_state_t state;
   ftl_state_t next_state;
   logic [7:0] osc_trim_first;
   logic [7:0] osc_trim_second;
   logic [7:0] reference_trim;
   logic [7:0] info_addr;
   logic [31:0] prdata;
   logic cpu_release;
   logic rd_valid;
   logic access_phase;
   logic hit_osc1;
   logic hit_osc2;
   logic hit_ref;
   logic hit_trim;
   logic hit_info;
   logic [7:0] info_byte_sel;
   logic trim_write;
   logic loading;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   // Only the low index bits are compared; the printed indices are too
   // wide to become byte addresses, so the map aliases on 4 KB.
   assign access_phase = psel_in && penable_in;
   assign hit_osc1 = paddr_in[11:2] == FTL_IDX_OSC_TRIM_FIRST[FTL_IDX_W-1:0];
   assign hit_osc2 = paddr_in[11:2] == FTL_IDX_OSC_TRIM_SECOND[FTL_IDX_W-1:0];
   assign hit_ref = paddr_in[11:2] == FTL_IDX_REFERENCE_TRIM[FTL_IDX_W-1:0];
   assign hit_trim = hit_osc1 || hit_osc2 || hit_ref;
   // Info window: one word per info byte above the base
   assign hit_info = paddr_in[11:10] == FTL_INFO_WIN_SEL;
   assign info_byte_sel = paddr_in[9:2];
   assign loading = state == FTL_ST_LOAD_OSC1 ||
                    state == FTL_ST_LOAD_OSC2 ||
                    state == FTL_ST_LOAD_REF;
   // Writes only land in the low byte lane of a trim register
   assign trim_write = state == FTL_ST_RUN && access_phase && pwrite_in &&
                       pstrb_in[0];

   // -----------------------------------------------------------------
   // Loader and bus sequencer
   // -----------------------------------------------------------------
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         FTL_ST_LOAD_OSC1: begin
            if (info_ack_in) begin
               next_state = FTL_ST_LOAD_OSC2;
            end
         end
         FTL_ST_LOAD_OSC2: begin
            if (info_ack_in) begin
               next_state = FTL_ST_LOAD_REF;
            end
         end
         FTL_ST_LOAD_REF: begin
            if (info_ack_in) begin
               next_state = FTL_ST_RUN; // R9
            end
         end
         FTL_ST_RUN: begin
            if (access_phase && hit_info && !pwrite_in) begin
               next_state = FTL_ST_INFO_WAIT; // R3
            end
         end
         FTL_ST_INFO_WAIT: begin
            if (info_ack_in) begin
               next_state = FTL_ST_INFO_DONE;
            end
         end
         FTL_ST_INFO_DONE: begin
            next_state = FTL_ST_RUN;
         end
         default: begin
            next_state = FTL_ST_LOAD_OSC1;
         end
      endcase
   end

   // State register; reset always restarts the load sequence
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= FTL_ST_LOAD_OSC1; // R2
      end else begin
         state <= next_state;
      end
   end

   // -----------------------------------------------------------------
   // Information area read port
   // -----------------------------------------------------------------
   // Request is held until acknowledged; the port has no write strobe
   // at all, so the factory bytes cannot be changed from here.
   assign info_req_out = loading || state == FTL_ST_INFO_WAIT; // R1

   // Info address steps through the three trim locations
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         info_addr <= FTL_INFO_OSC_FIRST; // R4
      end else if (state == FTL_ST_LOAD_OSC1 && info_ack_in) begin
         info_addr <= FTL_INFO_OSC_SECOND; // R4
      end else if (state == FTL_ST_LOAD_OSC2 && info_ack_in) begin
         info_addr <= FTL_INFO_REFERENCE; // R5
      end else if (state == FTL_ST_RUN && access_phase && hit_info &&
                   !pwrite_in) begin
         info_addr <= info_byte_sel; // R3
      end
   end
   assign info_addr_out = info_addr;

   // -----------------------------------------------------------------
   // Trim registers
   // -----------------------------------------------------------------
   // First oscillator trim: factory byte, then software
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         osc_trim_first <= FTL_TRIM_RESET;
      end else if (state == FTL_ST_LOAD_OSC1 && info_ack_in) begin
         osc_trim_first <= info_data_in; // R4
      end else if (trim_write && hit_osc1) begin
         osc_trim_first <= pwdata_in[7:0]; // R6
      end
   end

   // Second oscillator trim
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         osc_trim_second <= FTL_TRIM_RESET;
      end else if (state == FTL_ST_LOAD_OSC2 && info_ack_in) begin
         osc_trim_second <= info_data_in; // R4
      end else if (trim_write && hit_osc2) begin
         osc_trim_second <= pwdata_in[7:0]; // R6
      end
   end

   // Reference trim; stored as written, software keeps bits 7:5 at one
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reference_trim <= FTL_TRIM_RESET;
      end else if (state == FTL_ST_LOAD_REF && info_ack_in) begin
         reference_trim <= info_data_in; // R5
      end else if (trim_write && hit_ref) begin
         reference_trim <= pwdata_in[7:0]; // R7
      end
   end

   // Live trim values to oscillator and reference generator
   assign osc_trim_first_out = osc_trim_first; // R10
   assign osc_trim_second_out = osc_trim_second; // R10
   assign reference_trim_out = reference_trim; // R10
   assign reference_adjust_field_out =
      reference_trim[FTL_REF_ADJ_MSB:0]; // R8

   // -----------------------------------------------------------------
   // Release of software execution
   // -----------------------------------------------------------------
   // Registered so the release never precedes the last trim load
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cpu_release <= 1'b0;
      end else if (state == FTL_ST_LOAD_REF && info_ack_in) begin
         cpu_release <= 1'b1; // R9
      end
   end
   assign cpu_release_out = cpu_release;

   // -----------------------------------------------------------------
   // APB read data
   // -----------------------------------------------------------------
   // Trim data is captured in the first run cycle of a request, so a
   // read that waited out the reset load still sees the loaded byte;
   // info bytes arrive on acknowledge.
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata <= FTL_RDATA_RESET;
      end else if (state == FTL_ST_INFO_WAIT && info_ack_in) begin
         prdata <= {24'h000000, info_data_in}; // R3
      end else if (state == FTL_ST_RUN && psel_in && !rd_valid) begin
         if (hit_osc1) begin
            prdata <= {24'h000000, osc_trim_first}; // R6
         end else if (hit_osc2) begin
            prdata <= {24'h000000, osc_trim_second}; // R6
         end else if (hit_ref) begin
            prdata <= {24'h000000, reference_trim};
         end else begin
            prdata <= FTL_RDATA_RESET;
         end
      end
   end
   assign prdata_out = prdata;

   // Read data valid one cycle after its capture; cleared on completion
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= state == FTL_ST_RUN && psel_in &&
                     !(penable_in && pready_out); // R9
      end
   end

   // -----------------------------------------------------------------
   // APB completion and error
   // -----------------------------------------------------------------
   // Bus stalls during the reset load, so no read sees a partial value
   always_comb begin
      pready_out = 1'b0;
      pslverr_out = 1'b0;
      case (state)
         FTL_ST_RUN: begin
            if (access_phase) begin
               if (hit_trim) begin
                  pready_out = pwrite_in || rd_valid; // R9
               end else if (hit_info && pwrite_in) begin
                  pready_out = 1'b1;
                  pslverr_out = 1'b1; // R1
               end else if (!hit_info) begin
                  pready_out = pwrite_in || rd_valid;
                  pslverr_out = pwrite_in || rd_valid;
               end
            end
         end
         FTL_ST_INFO_DONE: begin
            pready_out = access_phase;
         end
         default: begin
            pready_out = 1'b0; // R9
         end
      endcase
   end

endmodule : ftl_trim_loader

// >>> testbench/ftl_trim_props.sv
// Checker for the trim loader: APB answers, reset load, trim outputs.
// Assumes a bind onto ftl_trim_loader; sees only its ports.
`timescale 1ns/100ps
module ftl_trim_props
   import ftl_pkg::*;
(
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [FTL_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic info_req_out,
   input wire logic [7:0] info_addr_out,
   input wire logic info_ack_in,
   input wire logic [7:0] info_data_in,
   input wire logic [7:0] osc_trim_first_out,
   input wire logic [7:0] reference_trim_out,
   input wire logic [FTL_REF_ADJ_MSB:0] reference_adjust_field_out,
   input wire logic cpu_release_out
);
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   // Completed APB write, and a load acknowledge at a given byte
   sequence s_wr;
      psel_in && penable_in && pready_out && pwrite_in;
   endsequence
   sequence s_ack(a);
      !cpu_release_out && info_req_out && info_ack_in && info_addr_out == a;
   endsequence
   property p_rdy; pready_out |-> penable_in && cpu_release_out; endproperty
   a_rdy: assert property (p_rdy) else $error("ready while loading");
   property p_info_wr; s_wr ##0 paddr_in[11:10] == 2'b01 |-> pslverr_out;
   endproperty
   a_info_wr: assert property (p_info_wr) else $error("info write ok");
   property p_osc1; s_ack(8'h21) |=> osc_trim_first_out == $past(info_data_in)
      && info_req_out && info_addr_out == 8'h22; endproperty
   a_osc1: assert property (p_osc1) else $error("first load wrong");
   property p_ref; s_ack(8'h23) |=> cpu_release_out
      && reference_trim_out == $past(info_data_in); endproperty
   a_ref: assert property (p_ref) else $error("reference load wrong");
   property p_hold; info_req_out && !info_ack_in |=> $stable(info_addr_out);
   endproperty
   a_hold: assert property (p_hold) else $error("info address moved");
   property p_wr1; s_wr ##0 (paddr_in == 12'hC94 && pstrb_in[0])
      |=> osc_trim_first_out == $past(pwdata_in[7:0]); endproperty
   a_wr1: assert property (p_wr1) else $error("trim write lost");
   property p_keep; cpu_release_out && !psel_in |=> $stable(osc_trim_first_out)
      && $stable(reference_trim_out); endproperty
   a_keep: assert property (p_keep) else $error("trim changed idle");
   property p_adj; s_wr ##0 (paddr_in == 12'hC9C && pstrb_in[0])
      |=> reference_adjust_field_out == $past(pwdata_in[4:0]); endproperty
   a_adj: assert property (p_adj) else $error("adjust field wrong");
   property p_rel; cpu_release_out |=> cpu_release_out; endproperty
   a_rel: assert property (p_rel) else $error("release dropped");
endmodule : ftl_trim_props

// >>> testbench/ftl_info_model.sv
// Factory information area model: read-only bytes on a req/ack port.
// Assumes the loader holds req and address until it samples the ack.
`timescale 1ns/100ps
module ftl_info_model #(
   parameter logic [7:0] F1 = 8'h00,
   parameter logic [7:0] F2 = 8'h00,
   parameter logic [7:0] F3 = 8'h00
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic slow_in,
   input wire logic info_req_in,
   input wire logic [7:0] info_addr_in,
   output logic info_ack_out,
   output logic [7:0] info_data_out
);
   // -----------------------------------------------------------------
   // Storage and answer
   // -----------------------------------------------------------------
   logic [2:0] wait_cnt;
   // No write port at all, so factory bytes cannot change
   function automatic logic [7:0] rom(input logic [7:0] a);
      case (a)
         8'h21: return F1;
         8'h22: return F2;
         8'h23: return F3;
         default: return 8'hFF;
      endcase
   endfunction : rom
   // Slow mode waits four cycles; data scrambled outside the ack
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_cnt <= 3'h0;
         info_ack_out <= 1'b0;
         info_data_out <= 8'h00;
      end else if (info_req_in && !info_ack_out
            && wait_cnt >= {slow_in, 2'b00}) begin
         wait_cnt <= 3'h0;
         info_ack_out <= 1'b1;
         info_data_out <= rom(info_addr_in);
      end else begin
         wait_cnt <= wait_cnt + {2'b00, info_req_in && !info_ack_out};
         info_ack_out <= 1'b0;
         info_data_out <= ~info_data_out;
      end
   end
endmodule : ftl_info_model

// >>> testbench/tb.sv
// Directed bench for the trim loader over APB with an info-area model.
// Assumes ftl_trim_props is bound below and 100 MHz clocking.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
   // -----------------------------------------------------------------
   // Signals and instances
   // -----------------------------------------------------------------
   localparam logic [7:0] F1 = 8'hA5;
   localparam logic [7:0] F2 = 8'h3C;
   localparam logic [7:0] F3 = 8'hF0;
   localparam logic [7:0] PAT [2] = '{8'hF0, 8'h0F};
   logic clk, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rstn = 1'b0;
   logic slow = 1'b1, pready, pslverr, req, ack, rel, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] iaddr, idata, t1, t2, t3;
   logic [4:0] adj;
   int mismatches = 0, n_checks = 0, cyc = 0;
   ftl_trim_loader DUT (.clock_in(clk), .rstn_in(rstn), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .info_req_out(req),
      .info_addr_out(iaddr), .info_ack_in(ack), .info_data_in(idata),
      .osc_trim_first_out(t1), .osc_trim_second_out(t2),
      .reference_trim_out(t3), .reference_adjust_field_out(adj),
      .cpu_release_out(rel));
   ftl_info_model #(.F1(F1), .F2(F2), .F3(F3)) u_info (.clock_in(clk),
      .rstn_in(rstn), .slow_in(slow), .info_req_in(req),
      .info_addr_in(iaddr), .info_ack_out(ack), .info_data_out(idata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard: about 150 cycles are expected
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   // One APB transfer; an idle edge first avoids double assignment
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK({err, w ? 32'h0 : rd}, e)
   endtask : xfer
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
   endtask : do_reset
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      do_reset();
      // First access lands while the slow load still runs
      xfer(1'b0, 12'hC94, 32'h0, 4'hF, {25'h0, F1});
      xfer(1'b0, 12'hC98, 32'h0, 4'hF, {25'h0, F2});
      xfer(1'b0, 12'hC9C, 32'h0, 4'hF, {25'h0, F3});
      `CHK({t1, t2, t3}, {F1, F2, F3})
      $display("load test done");
      foreach (PAT[i]) begin
         xfer(1'b1, 12'hC94, {24'h0, PAT[i]}, 4'h1, 33'h0);
         xfer(1'b1, 12'hC98, {24'h0, ~PAT[i]}, 4'h1, 33'h0);
         xfer(1'b0, 12'hC98, 32'h0, 4'hF, {25'h0, ~PAT[i]});
         `CHK({t1, t2}, {PAT[i], ~PAT[i]})
      end
      xfer(1'b1, 12'hC94, 32'hFF, 4'h0, 33'h0);
      xfer(1'b1, 12'hC9C, 32'hE7, 4'h1, 33'h0);
      xfer(1'b0, 12'hC9C, 32'h0, 4'hF, {25'h0, 8'hE7});
      `CHK({t1, t3, adj}, {8'h0F, 8'hE7, 5'h07})
      $display("override test done");
      // Info window shows factory bytes, refuses writes
      xfer(1'b0, 12'h484, 32'h0, 4'hF, {25'h0, F1});
      xfer(1'b1, 12'h484, 32'h0, 4'hF, {1'b1, 32'h0});
      xfer(1'b1, 12'h200, 32'hFF, 4'hF, {1'b1, 32'h0});
      xfer(1'b0, 12'h484, 32'h0, 4'hF, {25'h0, F1});
      xfer(1'b0, 12'h48C, 32'h0, 4'hF, {25'h0, F3});
      `CHK(t1, 8'h0F)
      $display("info test done");
      // Second reset with a prompt info area
      slow <= 1'b0;
      do_reset();
      while (rel !== 1'b1) @(posedge clk);
      `CHK({t1, t2, t3}, {F1, F2, F3})
      xfer(1'b1, 12'hC9C, 32'hF0, 4'h1, 33'h0);
      xfer(1'b0, 12'hC9C, 32'h0, 4'hF, {25'h0, 8'hF0});
      `CHK(adj, 5'h10)
      $display("reset test done");
      end_of_test();
   end
endmodule : tb
bind ftl_trim_loader ftl_trim_props u_props (.clock_in(clock_in),
   .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .pstrb_in(pstrb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .info_req_out(info_req_out), .info_addr_out(info_addr_out),
   .info_ack_in(info_ack_in), .info_data_in(info_data_in),
   .osc_trim_first_out(osc_trim_first_out),
   .reference_trim_out(reference_trim_out),
   .reference_adjust_field_out(reference_adjust_field_out),
   .cpu_release_out(cpu_release_out));
